//--- hw/adcs_pkg.sv
// constants, field layout and state type of the converter sequencer
// assumes a single 250 MHz clock that also stands for the oscillator
package adcs_pkg;
   localparam int RES_BITS = 10;
   localparam int TAD_PER_CONV = 12;
   // one instruction cycle is four oscillator periods
   localparam int TCY_CLKS = 4;
   localparam logic [1:0] TCY_LAST = 2'(TCY_CLKS - 1);
   localparam logic [3:0] TAD_PER_CONV_W = 4'(TAD_PER_CONV);

   // register byte offsets
   localparam logic [7:0] OFF_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_RES_HI = 8'h08;
   localparam logic [7:0] OFF_RES_LO = 8'h0c;
   localparam logic [7:0] OFF_ANA_MASK = 8'h10;
   localparam logic [7:0] OFF_PORT = 8'h14;
   localparam logic [7:0] OFF_FLAG = 8'h18;

   // field positions
   localparam int CTRL0_POWER = 0;
   localparam int CTRL0_GO = 2;
   localparam int CTRL0_CHS_LSB = 3;
   localparam int CTRL0_CLK_LSB = 6;
   localparam int CTRL1_CS2 = 6;
   localparam int CTRL1_JUST = 7;
   localparam int FLAG_DONE = 0;

   // values after reset
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] ANA_MASK_RST = 8'hff;
   localparam logic [7:0] RESULT_RST = 8'h00;

   localparam logic [1:0] CLK_LOW_RC = 2'h3;
   localparam logic [9:0] SAR_MSB = 10'h200;

   typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_DELAY, ST_SEG1, ST_BITS} adcs_state_t;
endpackage

//--- hw/adcs_sar_if.sv
// signals between the sequencer and the successive-approximation engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface adcs_sar_if;
   logic start;
   logic tick;
   logic abort;
   logic cmp;
   logic busy;
   logic done;
   logic [9:0] dac;
   logic [9:0] result;
   modport seq (output start, output tick, output abort, output cmp,
                input busy, input done, input dac, input result);
   modport core (input start, input tick, input abort, input cmp,
                 output busy, output done, output dac, output result);
endinterface

//--- hw/adcs_sar_core.sv
// successive-approximation engine: one bit decision per tick for ten ticks, result loaded on the eleventh
// assumes the comparator answer is settled when a tick arrives
`timescale 1ns/1ps
module adcs_sar_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sequencer side
   adcs_sar_if.core sar
);
   logic [9:0] code_q;
   logic [9:0] mask_q;
   logic [9:0] res_q;
   logic busy_q;
   logic fin_q;
   logic done_q;
   logic [9:0] code_kept;
   logic [9:0] mask_nx;
   logic step;

   // a low comparator answer drops the trial bit
   assign code_kept = sar.cmp ? code_q : (code_q & ~mask_q);
   assign mask_nx = mask_q >> 1;
   assign step = busy_q & sar.tick & ~sar.abort;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_q <= 10'h000;
         mask_q <= 10'h000;
         busy_q <= 1'b0;
         fin_q <= 1'b0;
      end
      else if (sar.abort)
      begin
         busy_q <= 1'b0;
         fin_q <= 1'b0;
      end
      else if (sar.start)
      begin
         busy_q <= 1'b1;
         fin_q <= 1'b0;
         code_q <= adcs_pkg::SAR_MSB;
         mask_q <= adcs_pkg::SAR_MSB;
      end
      else if (step && !fin_q)
      begin
         code_q <= code_kept | mask_nx;
         mask_q <= mask_nx;
         fin_q <= mask_q[0];
      end
      else if (step)
      begin
         busy_q <= 1'b0;
         fin_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q <= 1'b0;
         res_q <= 10'h000;
      end
      else
      begin
         done_q <= step & fin_q;
         if (step && fin_q)
         begin
            res_q <= code_q;
         end
      end
   end

   assign sar.busy = busy_q;
   assign sar.done = done_q;
   assign sar.dac = code_q;
   assign sar.result = res_q;
endmodule

//--- hw/adcs_top.sv
// converter sequencer: apb registers, conversion clock, sequencing, results
// assumes apb is clocked by mclk and the rc source arrives as a synchronous tick
// Function
// - a conversion takes twelve bit periods, ten of them with one bit decision each
// - three-bit select gives 2,4,8,16,32,64 oscillator periods or rc
// - port reads give zero on analog pins
// - selected pin is converted whatever its direction
// - sequencing ignores channel select and direction bits
// - clearing go during a conversion aborts it at once
// - an abort leaves the result pair unchanged
// - after an abort a new acquisition starts by itself
// - first segment lasts one full bit period with a divided clock, up to one bit period with rc
// - completion loads the 10-bit result into the 16-bit pair
// - unused six bits of the pair are written as zero
// - with converter off both result bytes are plain storage
// - conversion in sleep only with the rc clock selected
// - rc clock delays conversion start by one instruction cycle
// - sleep completion clears go, loads result, wakes if enabled
// - sleep with non-rc clock aborts and powers down, power bit kept
// - go starts a conversion when powered, cleared by hardware at end
// - completion clears go and sets the done flag with the load
// - justify 1 right-justifies, 0 left-justifies
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module adcs_top (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end
   input wire logic cmp_above,
   input wire logic rc_tick,
   output logic [9:0] dac_code,
   output logic [2:0] chan_sel,
   output logic track_en,
   output logic conv_power,
   // port pins
   input wire logic [7:0] pin_level,
   // processor state
   input wire logic sleep_mode,
   input wire logic done_irq_enable,
   output logic wake_req,
   output logic conversion_done_flag
);
   logic rst_meta_q;
   logic rst_n;
   adcs_pkg::adcs_state_t st_q;
   adcs_pkg::adcs_state_t st_d;
   logic [1:0] clk_low_q;
   logic [2:0] chs_q;
   logic power_q;
   logic go_q;
   logic go_d;
   logic just_q;
   logic cs2_q;
   logic [7:0] ana_mask_q;
   logic [7:0] res_hi_q;
   logic [7:0] res_lo_q;
   logic flag_q;
   logic wake_q;
   logic [31:0] prdata_q;
   logic [6:0] presc_q;
   logic [1:0] dly_q;
   adcs_sar_if sar ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [6:0] tad_div(input logic [2:0] sel);
      case (sel)
         3'h0: tad_div = 7'h02;
         3'h4: tad_div = 7'h04;
         3'h1: tad_div = 7'h08;
         3'h5: tad_div = 7'h10;
         3'h2: tad_div = 7'h20;
         3'h6: tad_div = 7'h40;
         default: tad_div = 7'h02;
      endcase
   endfunction

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // bus decode
   wire setup_ph = psel & ~penable;
   wire acc_wr = psel & penable & pwrite;
   wire addr_ok = hit(paddr, adcs_pkg::OFF_CTRL0) | hit(paddr, adcs_pkg::OFF_CTRL1) |
                  hit(paddr, adcs_pkg::OFF_RES_HI) | hit(paddr, adcs_pkg::OFF_RES_LO) |
                  hit(paddr, adcs_pkg::OFF_ANA_MASK) | hit(paddr, adcs_pkg::OFF_PORT) |
                  hit(paddr, adcs_pkg::OFF_FLAG);
   wire wr_ctrl0 = acc_wr & hit(paddr, adcs_pkg::OFF_CTRL0);
   wire wr_ctrl1 = acc_wr & hit(paddr, adcs_pkg::OFF_CTRL1);
   wire wr_hi = acc_wr & hit(paddr, adcs_pkg::OFF_RES_HI);
   wire wr_lo = acc_wr & hit(paddr, adcs_pkg::OFF_RES_LO);
   wire wr_mask = acc_wr & hit(paddr, adcs_pkg::OFF_ANA_MASK);
   wire wr_flag = acc_wr & hit(paddr, adcs_pkg::OFF_FLAG);
   wire go_wdata = pwdata[adcs_pkg::CTRL0_GO];
   wire [2:0] clk_sel = {cs2_q, clk_low_q};
   // only the rc source keeps running in sleep
   wire rc_sel = (clk_low_q == adcs_pkg::CLK_LOW_RC);
   // a non-rc clock powers the converter down in sleep, power bit kept
   wire power_eff = power_q & ~(sleep_mode & ~rc_sel);
   wire in_conv = (st_q == adcs_pkg::ST_SEG1) | (st_q == adcs_pkg::ST_BITS);
   wire running = in_conv | (st_q == adcs_pkg::ST_DELAY);
   // clearing go while running aborts immediately
   // a completion in the same cycle wins over a late abort, so its result still lands
   wire abort_sw = running & ~sar.done & wr_ctrl0 & ~go_wdata;
   wire abort_any = (abort_sw | (running & ~power_eff)) & ~sar.done;
   wire presc_tick = in_conv & (presc_q == tad_div(clk_sel) - 7'h01);
   wire tad_tick = rc_sel ? (in_conv & rc_tick) : presc_tick;
   wire [7:0] port_val = pin_level & ~ana_mask_q;
   wire [9:0] res = sar.result;

   // prescaler held at zero outside a conversion, so each one restarts it
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         presc_q <= 7'h00;
      end
      else
      begin
         presc_q <= (!in_conv || presc_tick) ? 7'h00 : presc_q + 7'h01;
      end
   end

   // rc start waits one instruction cycle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dly_q <= 2'h0;
      end
      else
      begin
         dly_q <= (st_q == adcs_pkg::ST_DELAY) ? dly_q + 2'h1 : 2'h0;
      end
   end

   // nothing below looks at channel select or pin direction
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         adcs_pkg::ST_OFF: st_d = adcs_pkg::ST_ACQ;
         adcs_pkg::ST_ACQ:
         begin
            if (go_q)
            begin
               st_d = rc_sel ? adcs_pkg::ST_DELAY : adcs_pkg::ST_SEG1;
            end
         end
         adcs_pkg::ST_DELAY:
         begin
            if (dly_q == adcs_pkg::TCY_LAST)
            begin
               st_d = adcs_pkg::ST_SEG1;
            end
         end
         // first segment ends on the first bit-period tick
         adcs_pkg::ST_SEG1:
         begin
            if (tad_tick)
            begin
               st_d = adcs_pkg::ST_BITS;
            end
         end
         adcs_pkg::ST_BITS:
         begin
            if (sar.done)
            begin
               st_d = adcs_pkg::ST_ACQ;
            end
         end
         default: st_d = adcs_pkg::ST_OFF;
      endcase
      // a software abort drops back to acquisition; losing power goes to off instead
      if (abort_sw)
      begin
         st_d = adcs_pkg::ST_ACQ;
      end
      if (!power_eff)
      begin
         st_d = adcs_pkg::ST_OFF;
      end
   end

   // go only takes while already powered; hardware clears it at the end
   always_comb
   begin
      // a write that powers down cannot leave go standing
      go_d = wr_ctrl0 ? (go_wdata & power_q & pwdata[adcs_pkg::CTRL0_POWER]) : go_q;
      // completion clears go together with the load
      if (sar.done || !power_eff)
      begin
         go_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= adcs_pkg::ST_OFF;
         go_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         go_q <= go_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_low_q <= adcs_pkg::CTRL0_RST[7:6];
         chs_q <= adcs_pkg::CTRL0_RST[5:3];
         power_q <= adcs_pkg::CTRL0_RST[0];
         just_q <= adcs_pkg::CTRL1_RST[7];
         cs2_q <= adcs_pkg::CTRL1_RST[6];
         ana_mask_q <= adcs_pkg::ANA_MASK_RST;
      end
      else
      begin
         if (wr_ctrl0)
         begin
            clk_low_q <= pwdata[adcs_pkg::CTRL0_CLK_LSB +: 2];
            chs_q <= pwdata[adcs_pkg::CTRL0_CHS_LSB +: 3];
            power_q <= pwdata[adcs_pkg::CTRL0_POWER];
         end
         if (wr_ctrl1)
         begin
            just_q <= pwdata[adcs_pkg::CTRL1_JUST];
            cs2_q <= pwdata[adcs_pkg::CTRL1_CS2];
         end
         if (wr_mask)
         begin
            ana_mask_q <= pwdata[7:0];
         end
      end
   end

   // software writes are plain storage; a completion in the same cycle wins
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_hi_q <= adcs_pkg::RESULT_RST;
         res_lo_q <= adcs_pkg::RESULT_RST;
      end
      else if (sar.done)
      begin
         res_hi_q <= just_q ? {6'h00, res[9:8]} : res[9:2];
         res_lo_q <= just_q ? res[7:0] : {res[1:0], 6'h00};
      end
      else
      begin
         if (wr_hi)
         begin
            res_hi_q <= pwdata[7:0];
         end
         if (wr_lo)
         begin
            res_lo_q <= pwdata[7:0];
         end
      end
   end

   // done flag: write one clears, a completion in the same cycle wins
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         flag_q <= sar.done | (flag_q & ~(wr_flag & pwdata[adcs_pkg::FLAG_DONE]));
         // wake only when the interrupt is enabled
         wake_q <= sar.done & sleep_mode & done_irq_enable;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else if (setup_ph)
      begin
         prdata_q <= 32'h0000_0000;
         if (hit(paddr, adcs_pkg::OFF_CTRL0))
         begin
            prdata_q[7:0] <= {clk_low_q, chs_q, go_q, 1'b0, power_q};
         end
         if (hit(paddr, adcs_pkg::OFF_CTRL1))
         begin
            prdata_q[7:0] <= {just_q, cs2_q, 6'h00};
         end
         if (hit(paddr, adcs_pkg::OFF_RES_HI))
         begin
            prdata_q[7:0] <= res_hi_q;
         end
         if (hit(paddr, adcs_pkg::OFF_RES_LO))
         begin
            prdata_q[7:0] <= res_lo_q;
         end
         if (hit(paddr, adcs_pkg::OFF_ANA_MASK))
         begin
            prdata_q[7:0] <= ana_mask_q;
         end
         if (hit(paddr, adcs_pkg::OFF_PORT))
         begin
            prdata_q[7:0] <= port_val;
         end
         if (hit(paddr, adcs_pkg::OFF_FLAG))
         begin
            prdata_q[adcs_pkg::FLAG_DONE] <= flag_q;
         end
      end
   end

   // twelve bit periods: the first segment plus eleven engine ticks
   assign sar.start = (st_q == adcs_pkg::ST_SEG1) & tad_tick & ~abort_any;
   assign sar.tick = (st_q == adcs_pkg::ST_BITS) & tad_tick;
   assign sar.abort = abort_any;
   assign sar.cmp = cmp_above;

   adcs_sar_core u_core (
      .clk(mclk),
      .rst_n(rst_n),
      .sar(sar)
   );

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   // the mux takes the selected pin whatever its direction
   assign chan_sel = chs_q;
   assign dac_code = sar.dac;
   assign track_en = (st_q == adcs_pkg::ST_ACQ);
   assign conv_power = power_eff;
   assign wake_req = wake_q;
   assign conversion_done_flag = flag_q;

   // checking helpers
   logic [3:0] tad_cnt_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tad_cnt_q <= 4'h0;
      end
      else
      begin
         tad_cnt_q <= !in_conv ? 4'h0 : (tad_tick ? tad_cnt_q + 4'h1 : tad_cnt_q);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_conv_length: assert property (sar.done |-> tad_cnt_q == adcs_pkg::TAD_PER_CONV_W)
      else $error("conversion did not last twelve bit periods");
   a_presc_period: assert property (presc_tick |-> $past(presc_q) == tad_div(clk_sel) - 7'h02 ||
      tad_div(clk_sel) == 7'h02 || $past(!in_conv))
      else $error("prescaler period does not match clock select");
   a_port_analog: assert property ((setup_ph && hit(paddr, adcs_pkg::OFF_PORT)) |=>
      (prdata[7:0] & ana_mask_q) == 8'h00)
      else $error("analog pin read back as high");
   a_abort_acq: assert property (abort_sw && power_eff |=> st_q == adcs_pkg::ST_ACQ && !sar.busy)
      else $error("abort did not return to acquisition");
   a_abort_keep: assert property ((abort_any && !wr_hi && !wr_lo) |=>
      $stable(res_hi_q) && $stable(res_lo_q))
      else $error("abort changed the result pair");
   a_rc_delay: assert property ((st_q == adcs_pkg::ST_SEG1 && $past(st_q) == adcs_pkg::ST_DELAY) |->
      $past(dly_q) == adcs_pkg::TCY_LAST)
      else $error("rc start delay is not one instruction cycle");
   a_seg1_bound: assert property (($rose(st_q == adcs_pkg::ST_SEG1) && !rc_sel && !sleep_mode) |->
      ##[1:64] st_q != adcs_pkg::ST_SEG1)
      else $error("first segment longer than one bit period");
   a_done_flags: assert property (sar.done |=> flag_q && !go_q)
      else $error("completion did not set flag and clear go");
   a_just_zero: assert property (sar.done |=> (just_q ? res_hi_q[7:2] == 6'h00 :
      res_lo_q[5:0] == 6'h00))
      else $error("spare result bits not zero");
   a_sleep_abort: assert property ((sleep_mode && !rc_sel && running) |=>
      st_q == adcs_pkg::ST_OFF && !sar.busy && $stable(power_q))
      else $error("non-rc sleep did not abort");
   a_sleep_wake: assert property ((sar.done && sleep_mode) |=> wake_req == $past(done_irq_enable))
      else $error("sleep completion wake mismatch");
   a_go_power: assert property (go_q |-> power_q)
      else $error("go set without power");

   c_complete: cover property (sar.done);
   c_sw_abort: cover property (abort_sw);
   c_sleep_done: cover property (sar.done && sleep_mode && rc_sel);
   c_sleep_abort: cover property (sleep_mode && !rc_sel && running);
endmodule

//--- verif/adcs_analog_model.sv
// analog side: pin voltage held as a code, comparator and rc bit clock
// assumes dac_code settles well before the next bit tick
`timescale 1ns/1ps
module adcs_analog_model #(
   parameter int RC_DIV = 6
) (
   // clock
   input wire logic mclk,
   // bench control
   input wire logic rc_run,
   input wire logic [9:0] vin,
   // converter side
   input wire logic [9:0] dac_code,
   output logic cmp_above,
   output logic rc_tick
);
   int cnt = 0;
   // ideal comparator settles at once, so no bit period is too short here
   // ideal comparator, pin level taken whatever its direction
   assign cmp_above = (vin >= dac_code);
   // rc source stands still unless the bench lets it run
   always @(posedge mclk)
   begin
      if (!rc_run)
      begin
         cnt <= 0;
         rc_tick <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
         rc_tick <= (cnt == RC_DIV - 1);
      end
   end
endmodule

//--- verif/adc_conversion_sequencer_bench.sv
// self-checking bench: apb master, random conversions, abort and sleep cases
// assumes an ideal comparator, so a finished conversion returns the pin code
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
   logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, pin_level = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h47;
   logic pready, pslverr, cmp_above, rc_tick, track_en, conv_power, wake_req, err;
   logic sleep_mode = 1'b0, done_irq_enable = 1'b0, rc_run = 1'b0;
   logic [9:0] dac_code, vin = 10'h000;
   logic [2:0] chan_sel;
   logic conversion_done_flag;
   logic [15:0] last_pair = 16'h0000;
   int n_fail = 0, compares = 0, wakes = 0, w0 = 0;

   always #2 mclk = ~mclk;
   always @(posedge mclk)
   begin
      if (wake_req === 1'b1)
         wakes <= wakes + 1;
   end

   adcs_top DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_above(cmp_above), .rc_tick(rc_tick), .dac_code(dac_code),
      .chan_sel(chan_sel), .track_en(track_en), .conv_power(conv_power),
      .pin_level(pin_level), .sleep_mode(sleep_mode), .done_irq_enable(done_irq_enable),
      .wake_req(wake_req), .conversion_done_flag(conversion_done_flag));
   adcs_analog_model #(.RC_DIV(6)) model (.mclk(mclk), .rc_run(rc_run), .vin(vin),
      .dac_code(dac_code), .cmp_above(cmp_above), .rc_tick(rc_tick));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int tad_of(logic [2:0] cs);
      case (cs)
         3'h0: return 2;
         3'h4: return 4;
         3'h1: return 8;
         3'h5: return 16;
         3'h2: return 32;
         default: return 64;
      endcase
   endfunction
   function automatic logic [15:0] pair_of(logic [9:0] v, logic just);
      return just ? {6'h00, v} : {v, 6'h00};
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one transfer, then an idle edge so the next one never reassigns psel
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         chk("pready_wait", 0, 1);
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_flag(output int n);
      n = 0;
      while (conversion_done_flag !== 1'b1 && n < 2000)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= 2000)
      begin
         chk("done_wait", 0, 1);
         conclude();
      end
      @(posedge mclk);
   endtask
   task automatic check_pair();
      apb(0, adcs_pkg::OFF_RES_HI, 8'h00);
      chk("res_hi", rd, {24'h0, last_pair[15:8]});
      apb(0, adcs_pkg::OFF_RES_LO, 8'h00);
      chk("res_lo", rd, {24'h0, last_pair[7:0]});
   endtask
   task automatic convert(input logic [2:0] cs, input logic just, input logic [9:0] v);
      int n;
      logic [2:0] ch;
      ch = 3'(xs());
      vin <= v;
      apb(1, adcs_pkg::OFF_CTRL1, {just, cs[2], 6'h00});
      // power up in a write of its own
      apb(1, adcs_pkg::OFF_CTRL0, {cs[1:0], ch, 3'h1});
      chk("chan_sel", chan_sel, ch);
      repeat (8) @(posedge mclk);
      apb(1, adcs_pkg::OFF_CTRL0, {cs[1:0], ch, 3'h5});
      wait_flag(n);
      chk("conv_cycles", n >= 12 * tad_of(cs) - 1 && n <= 12 * tad_of(cs) + 4, 1);
      last_pair = pair_of(v, just);
      check_pair();
      apb(0, adcs_pkg::OFF_CTRL0, 8'h00);
      chk("go_clear", rd, {24'h0, cs[1:0], ch, 3'h1});
      apb(1, adcs_pkg::OFF_FLAG, 8'h01);
      chk("flag_clear", conversion_done_flag, 0);
   endtask

   logic [7:0] ra[8] = '{adcs_pkg::OFF_CTRL0, adcs_pkg::OFF_CTRL1, adcs_pkg::OFF_RES_HI,
      adcs_pkg::OFF_RES_LO, adcs_pkg::OFF_ANA_MASK, adcs_pkg::OFF_PORT, adcs_pkg::OFF_FLAG,
      8'h1c};
   logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
   logic [2:0] css[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
   logic [7:0] m;
   int n;

   initial
   begin
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      pin_level <= 8'(xs());
      repeat (4) @(posedge mclk);
      foreach (ra[i])
      begin
         apb(0, ra[i], 8'h00);
         chk("reset_value", rd, {24'h0, rv[i]});
         chk("slave_error", err, i == 7);
      end
      $display("test reset done");
      last_pair = 16'(xs());
      apb(1, adcs_pkg::OFF_RES_HI, last_pair[15:8]);
      apb(1, adcs_pkg::OFF_RES_LO, last_pair[7:0]);
      check_pair();
      m = 8'(xs());
      apb(1, adcs_pkg::OFF_ANA_MASK, m);
      apb(0, adcs_pkg::OFF_PORT, 8'h00);
      chk("port_read", rd, {24'h0, pin_level & ~m});
      apb(1, adcs_pkg::OFF_CTRL0, 8'h05);
      apb(0, adcs_pkg::OFF_CTRL0, 8'h00);
      chk("same_write_go", rd, 32'h1);
      $display("test storage and port done");
      foreach (css[i])
         convert(css[i], 1'(xs()), (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'(xs()));
      $display("test conversions done");
      apb(1, adcs_pkg::OFF_CTRL1, 8'h00);
      apb(1, adcs_pkg::OFF_CTRL0, 8'h05);
      repeat (6) @(posedge mclk);
      apb(1, adcs_pkg::OFF_CTRL0, 8'h01);
      @(negedge mclk);
      chk("abort_track", track_en, 1);
      repeat (40) @(posedge mclk);
      chk("abort_flag", conversion_done_flag, 0);
      check_pair();
      $display("test abort done");
      apb(1, adcs_pkg::OFF_CTRL0, 8'h81);
      apb(1, adcs_pkg::OFF_CTRL0, 8'h85);
      repeat (10) @(posedge mclk);
      sleep_mode <= 1'b1;
      repeat (2) @(negedge mclk);
      chk("sleep_power", conv_power, 0);
      repeat (500) @(posedge mclk);
      apb(0, adcs_pkg::OFF_CTRL0, 8'h00);
      chk("sleep_bits", rd, 32'h81);
      chk("sleep_flag", conversion_done_flag, 0);
      sleep_mode <= 1'b0;
      $display("test sleep abort done");
      for (int irq = 0; irq < 2; irq++)
      begin
         vin <= 10'(xs());
         // top select bit differs per pass, so both rc codes are used
         apb(1, adcs_pkg::OFF_CTRL1, {1'b0, 1'(irq), 6'h00});
         apb(1, adcs_pkg::OFF_CTRL0, 8'hc1);
         w0 = wakes;
         apb(1, adcs_pkg::OFF_CTRL0, 8'hc5);
         sleep_mode <= 1'b1;
         rc_run <= 1'b1;
         done_irq_enable <= 1'(irq);
         wait_flag(n);
         chk("rc_start_delay", n > 6, 1);
         repeat (3) @(posedge mclk);
         chk("wake", wakes - w0, irq);
         last_pair = pair_of(vin, 1'b0);
         check_pair();
         apb(0, adcs_pkg::OFF_CTRL0, 8'h00);
         chk("rc_bits", rd, 32'hc1);
         sleep_mode <= 1'b0;
         rc_run <= 1'b0;
         apb(1, adcs_pkg::OFF_FLAG, 8'h01);
      end
      $display("test rc sleep done");
      conclude();
   end
endmodule
